// *** rtl/scd_ctrl.v ***
// Command decode, hysteretic regulation and dither for current driver one
`timescale 1ns/1ps
`include "scd_consts.vh"
module scd_ctrl
#(
   parameter CLK_HZ  = `SCD_CLK_HZ,
   parameter DCNT_W  = 20
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Serial link pins
   input  wire        spi_cs_n,
   input  wire        spi_sclk,
   input  wire        spi_mosi,
   output reg         spi_miso,
   output reg         spi_miso_oe,
   // Sensed output current, same units as the target code
   input  wire [9:0]  sense_code,
   // Raw fault and status inputs from the protection logic
   input  wire        overvoltage_fault,
   input  wire        thermal_limit_fault,
   input  wire        cal_fault,
   input  wire        trim_set,
   input  wire        supply_cal_source,
   input  wire        open_fault_one,
   input  wire        short_fault_one,
   input  wire        open_fault_two,
   input  wire        short_fault_two,
   input  wire [7:0]  out_fault,
   // Driver controls
   output reg         drv_on,
   output reg         diag_pull_direction,
   output reg         switch_mode,
   output reg  [9:0]  eff_target
);

   // Synchronised link pins
   wire       cs_n_s;
   wire       sclk_s;
   wire       mosi_s;
   reg        cs_n_d_q;
   reg        sclk_d_q;

   scd_sync2 #(.RST_VAL(1'b1)) u_sync_cs
   (
      .clk   (clk),
      .reset (reset),
      .din   (spi_cs_n),
      .dout  (cs_n_s)
   );

   scd_sync2 #(.RST_VAL(1'b0)) u_sync_sclk
   (
      .clk   (clk),
      .reset (reset),
      .din   (spi_sclk),
      .dout  (sclk_s)
   );

   scd_sync2 #(.RST_VAL(1'b0)) u_sync_mosi
   (
      .clk   (clk),
      .reset (reset),
      .din   (spi_mosi),
      .dout  (mosi_s)
   );

   wire cs_fall   = cs_n_d_q & ~cs_n_s;
   wire cs_rise   = ~cs_n_d_q & cs_n_s;
   wire sclk_rise = ~cs_n_s & ~sclk_d_q & sclk_s;
   wire sclk_fall = ~cs_n_s & sclk_d_q & ~sclk_s;

   // Receive and transmit shifters
   reg [15:0] rx_q;
   reg [15:0] tx_q;
   reg [4:0]  bit_cnt_q;
   reg        por_flag_q;
   reg [15:0] flt_q;

   // Command state
   reg                target_q;
   reg [8:0]          tgt_q;
   reg                dither_disable_q;
   reg                fault_retry_select_q;
   reg                on_off_q;
   reg [2:0]          amp_pend_q;
   reg [3:0]          freq_pend_q;
   reg [2:0]          amp_act_q;
   reg [3:0]          freq_act_q;
   reg                pend_q;

   // Dither timing
   reg [DCNT_W-1:0]   dcnt_q;
   reg                phase_pos_q;

   // Protection
   reg                prot_off_q;

   // Raw fault vector in response layout
   wire combined_fault = overvoltage_fault | thermal_limit_fault | cal_fault;
   wire [15:0] flt_raw = {combined_fault, 1'b0, trim_set, supply_cal_source,
                          open_fault_two, short_fault_two, open_fault_one,
                          short_fault_one, out_fault};
   wire [15:0] resp_word = {flt_q[15], por_flag_q, flt_q[13:0]};

   // Half period of the dither square in clock cycles
   function [DCNT_W-1:0] half_cnt;
      input [3:0] code;
      integer     v;
      begin
         v = 0;
         case (code)
            4'h1:    v = CLK_HZ / 100;
            4'h2:    v = CLK_HZ / 200;
            4'h3:    v = CLK_HZ / 300;
            4'h4:    v = CLK_HZ / 400;
            4'h5:    v = CLK_HZ / 500;
            4'h6:    v = CLK_HZ / 600;
            4'h7:    v = CLK_HZ / 700;
            4'h8:    v = CLK_HZ / 800;
            4'h9:    v = CLK_HZ / 900;
            4'hA:    v = CLK_HZ / 1000;
            4'hB:    v = CLK_HZ / 266;
            4'hC:    v = CLK_HZ / 332;
            4'hD:    v = CLK_HZ / 466;
            4'hE:    v = CLK_HZ / 532;
            default: v = 1;
         endcase
         half_cnt = v[DCNT_W-1:0];
      end
   endfunction

   // Dither amplitude and lockout
   localparam [10:0] AMP_LSB = `SCD_AMP_STEP_LSB;
   wire [10:0] amp_code = {8'h00, amp_act_q} * AMP_LSB;
   wire [10:0] tgt_w    = {2'b00, tgt_q};
   wire [10:0] tgt_hi   = tgt_w + amp_code;
   wire        lock_hi  = tgt_hi >= `SCD_FULL_SCALE_CODE;
   wire        lock_lo  = tgt_w <= amp_code;
   wire        dith_on  = ~dither_disable_q & (amp_act_q != 3'h0) &
                          (freq_act_q != 4'h0) & ~lock_hi & ~lock_lo;

   wire [10:0] eff_w    = !dith_on ? tgt_w :
                          (phase_pos_q ? tgt_hi : (tgt_w - amp_code));
   wire [17:0] band_p   = {7'h00, eff_w} * 18'd`SCD_SWITCH_PCT;
   wire [17:0] band_div = band_p / 18'd100;
   wire [10:0] band     = band_div[10:0];
   wire [11:0] upper_sp = {1'b0, eff_w} + {1'b0, band};
   wire [11:0] lower_sp = {1'b0, eff_w} - {1'b0, band};
   wire [11:0] sense_w  = {2'b00, sense_code};

   wire [4:0]  rx_addr  = rx_q[`SCD_ADDR_HI:`SCD_ADDR_LO];
   wire        word_ok  = cs_rise & (bit_cnt_q == 5'd`SCD_WORD_BITS);
   wire        wr_tgt   = word_ok & (rx_addr == `SCD_ADDR_TARGET);
   wire        wr_dith  = word_ok & (rx_addr == `SCD_ADDR_DITHER);

   // Link framing and response shifting
   always @(posedge clk)
   begin
      if (reset)
      begin
         cs_n_d_q    <= 1'b1;
         sclk_d_q    <= 1'b0;
         rx_q        <= 16'h0000;
         tx_q        <= 16'h0000;
         bit_cnt_q   <= 5'h00;
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
      end
      else
      begin
         cs_n_d_q    <= cs_n_s;
         sclk_d_q    <= sclk_s;
         spi_miso_oe <= ~cs_n_s;
         if (cs_fall)
         begin
            tx_q      <= {resp_word[14:0], 1'b0};
            spi_miso  <= resp_word[15];
            bit_cnt_q <= 5'h00;
         end
         else
         begin
            if (sclk_rise)
            begin
               rx_q <= {rx_q[14:0], mosi_s};
               if (bit_cnt_q != 5'h1F)
                  bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            if (sclk_fall)
            begin
               spi_miso <= tx_q[15];
               tx_q     <= {tx_q[14:0], 1'b0};
            end
         end
      end
   end

   // Fault latches
   always @(posedge clk)
   begin
      if (reset)
      begin
         flt_q      <= 16'h0000;
         por_flag_q <= 1'b1;
      end
      else
      begin
         // clear at frame end, but a fault present now re-sets
         if (cs_rise)
         begin
            flt_q      <= flt_raw;
            por_flag_q <= 1'b0;
         end
         else
            flt_q <= flt_q | flt_raw;
      end
   end

   // Command registers
   always @(posedge clk)
   begin
      if (reset)
      begin
         target_q             <= 1'b0;
         tgt_q                <= `SCD_TARGET_RST;
         diag_pull_direction  <= 1'b0;
         dither_disable_q     <= 1'b0;
         fault_retry_select_q <= 1'b0;
         on_off_q             <= 1'b0;
         switch_mode          <= 1'b0;
         amp_pend_q           <= `SCD_AMP_RST;
         freq_pend_q          <= `SCD_CODE_RST;
         pend_q               <= 1'b0;
      end
      else
      begin
         target_q <= 1'b1;
         if (wr_tgt)
         begin
            diag_pull_direction <= rx_q[`SCD_DIAG_BIT];
            dither_disable_q    <= rx_q[`SCD_DDIS_BIT];
            tgt_q               <= rx_q[`SCD_TGT_HI:0];
         end
         if (wr_dith)
         begin
            fault_retry_select_q <= rx_q[`SCD_RETRY_BIT];
            on_off_q             <= rx_q[`SCD_ONOFF_BIT];
            switch_mode          <= rx_q[`SCD_SWMODE_BIT];
            amp_pend_q           <= rx_q[`SCD_AMP_HI:`SCD_AMP_LO];
            if (rx_q[`SCD_FREQ_HI:`SCD_FREQ_LO] != `SCD_FREQ_KEEP)
               freq_pend_q <= rx_q[`SCD_FREQ_HI:`SCD_FREQ_LO];
            pend_q <= 1'b1;
         end
         else if (pend_q & (dcnt_q == {DCNT_W{1'b0}}) & (~phase_pos_q | ~dith_on))
            pend_q <= 1'b0;
      end
   end

   // New period must start together with the new amplitude
   wire        swap_now = ~phase_pos_q & pend_q & ~wr_dith;

   // Dither phase generator
   always @(posedge clk)
   begin
      if (reset)
      begin
         dcnt_q      <= {DCNT_W{1'b0}};
         phase_pos_q <= 1'b0;
         amp_act_q   <= `SCD_AMP_RST;
         freq_act_q  <= `SCD_CODE_RST;
      end
      else if (!dith_on)
      begin
         // Idle dither: phase held negative, a pending change is applied now
         dcnt_q      <= {DCNT_W{1'b0}};
         phase_pos_q <= 1'b0;
         if (pend_q & ~wr_dith)
         begin
            amp_act_q  <= amp_pend_q;
            freq_act_q <= freq_pend_q;
         end
      end
      else if (dcnt_q == {DCNT_W{1'b0}})
      begin
         // half period from the frequency code
         dcnt_q      <= half_cnt(swap_now ? freq_pend_q : freq_act_q) -
                        {{(DCNT_W-1){1'b0}}, 1'b1};
         phase_pos_q <= ~phase_pos_q;
         // swap settings only entering a positive half
         if (swap_now)
         begin
            amp_act_q  <= amp_pend_q;
            freq_act_q <= freq_pend_q;
         end
      end
      else
         dcnt_q <= dcnt_q - {{(DCNT_W-1){1'b0}}, 1'b1};
   end

   // Protection shutdown
   wire prot_trip = short_fault_one | overvoltage_fault | thermal_limit_fault;

   always @(posedge clk)
   begin
      if (reset)
         prot_off_q <= 1'b0;
      else if (prot_trip)
         prot_off_q <= 1'b1;
      else if (fault_retry_select_q | wr_tgt | wr_dith)
         prot_off_q <= 1'b0;
   end

   // Output drive
   always @(posedge clk)
   begin
      if (reset)
      begin
         drv_on     <= 1'b0;
         eff_target <= 10'h000;
      end
      else
      begin
         eff_target <= eff_w[9:0];
         if (prot_off_q | prot_trip | ~target_q)
            drv_on <= 1'b0;
         else if (switch_mode)
            drv_on <= on_off_q;
         // zero target keeps the driver off
         else if (eff_w == 11'h000)
            drv_on <= 1'b0;
         // off at upper point, wins when the band is empty
         else if (sense_w >= upper_sp)
            drv_on <= 1'b0;
         else if (sense_w <= lower_sp)
            drv_on <= 1'b1;
      end
   end

endmodule // scd_ctrl

// *** rtl/scd_consts.vh ***
// Constants for the solenoid current controller with dither
`ifndef SCD_CONSTS_VH
`define SCD_CONSTS_VH

`define SCD_WORD_BITS       16
`define SCD_ADDR_HI         15
`define SCD_ADDR_LO         11
`define SCD_ADDR_TARGET     5'h16
`define SCD_ADDR_DITHER     5'h17
`define SCD_DIAG_BIT        10
`define SCD_DDIS_BIT        9
`define SCD_TGT_HI          8
`define SCD_RETRY_BIT       10
`define SCD_ONOFF_BIT       9
`define SCD_SWMODE_BIT      8
`define SCD_AMP_HI          6
`define SCD_AMP_LO          4
`define SCD_FREQ_HI         3
`define SCD_FREQ_LO         0
`define SCD_FREQ_KEEP       4'hF
`define SCD_FULL_SCALE_MA   1075
`define SCD_FULL_SCALE_CODE 11'h1FF
`define SCD_AMP_STEP_DMA    504
`define SCD_AMP_STEP_LSB    ((`SCD_AMP_STEP_DMA * 511 + `SCD_FULL_SCALE_MA * 5) / (`SCD_FULL_SCALE_MA * 10))
`define SCD_SWITCH_PCT      5
`define SCD_CLK_HZ          100000000
`define SCD_TARGET_RST      9'h000
`define SCD_CODE_RST        4'h0
`define SCD_AMP_RST         3'h0

`endif

// *** rtl/scd_sync2.v ***
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module scd_sync2
#(
   parameter RST_VAL = 1'b0
)
(
   // Clock and reset
   input  wire clk,
   input  wire reset,
   // Asynchronous level in, synchronised level out
   input  wire din,
   output reg  dout
);

   reg meta_q;

   always @(posedge clk)
   begin
      if (reset)
      begin
         meta_q <= RST_VAL;
         dout   <= RST_VAL;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule // scd_sync2

// *** bench/scd_spi_host.sv ***
// Serial link host model that sends command words
`timescale 1ns/1ps
module scd_spi_host
(
   // Pacing clock
   input  wire  clk,
   // Link pins
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input  wire  miso
);
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
      r = 16'h0000;
      wt(1);
      cs_n = 1'b0;
      for (int i = nb - 1; i >= 0; i--)
      begin
         mosi = w[i];
         wt(4);
         sclk = 1'b1;
         r = {r[14:0], miso};
         wt(4);
         sclk = 1'b0;
      end
      // Released line must not keep its last level
      mosi = ~mosi;
      cs_n = 1'b1;
      wt(8);
   endtask
endmodule // scd_spi_host

// *** bench/scd_ctrl_properties.sv ***
// Port-level checks for the solenoid current controller
`timescale 1ns/1ps
module scd_ctrl_properties
(
   // Clock and reset
   input wire       clk,
   input wire       reset,
   // Link
   input wire       spi_cs_n,
   input wire       spi_miso_oe,
   // Sense and trips
   input wire [9:0] sense_code,
   input wire       overvoltage_fault,
   input wire       thermal_limit_fault,
   input wire       short_fault_one,
   // Driver controls
   input wire       drv_on,
   input wire       diag_pull_direction,
   input wire       switch_mode,
   input wire [9:0] eff_target
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence cs_low_held;
      (!spi_cs_n) [*5];
   endsequence
   sequence cs_high_held;
      spi_cs_n [*5];
   endsequence
   a_upper_off: assert property (
      !$past(switch_mode) && $past(sense_code) >= eff_target + eff_target * 5 / 100
      |-> !drv_on)
      else $error("driver left on at upper point");
   a_lower_on: assert property (
      $rose(drv_on) && !$past(switch_mode)
      |-> $past(sense_code) <= eff_target - eff_target * 5 / 100)
      else $error("driver turned on above lower point");
   a_trip_off: assert property (
      overvoltage_fault || thermal_limit_fault || short_fault_one |-> ##[1:2] !drv_on)
      else $error("driver on during trip");
   a_eff_range: assert property (
      eff_target <= 10'h1FF)
      else $error("target beyond full scale");
   a_resp_drive: assert property (
      cs_low_held |-> spi_miso_oe)
      else $error("response line not driven in frame");
   a_resp_release: assert property (
      cs_high_held |-> !spi_miso_oe)
      else $error("response line driven outside frame");
   a_diag_after_cs: assert property (
      $changed(diag_pull_direction) |-> $past(spi_cs_n, 3) && $past(spi_cs_n, 2) && $past(spi_cs_n))
      else $error("pull direction changed inside frame");
   a_mode_after_cs: assert property (
      $changed(switch_mode) |-> $past(spi_cs_n, 3) && $past(spi_cs_n, 2) && $past(spi_cs_n))
      else $error("mode changed inside frame");
endmodule // scd_ctrl_properties

// *** bench/scd_ctrl_tb.sv ***
// Self-checking bench for the solenoid current controller
`timescale 1ns/1ps
`include "scd_consts.vh"
module scd_ctrl_tb;
   typedef struct packed {logic g; logic [8:0] t; logic [9:0] s; logic d;} scd_row_t;
   // Short dither periods keep the run brief
   localparam int CLK_HZ = 10000;
   logic clk = 1'b0, reset = 1'b1;
   wire spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, drv_on;
   wire diag_pull_direction, switch_mode;
   wire [9:0] eff_target;
   logic [9:0] sense_code = 10'h000;
   logic overvoltage_fault = 1'b1, thermal_limit_fault = 1'b0, cal_fault = 1'b0;
   logic trim_set = 1'b1, supply_cal_source = 1'b1, open_fault_one = 1'b0;
   logic short_fault_one = 1'b1, open_fault_two = 1'b1, short_fault_two = 1'b0;
   logic [7:0] out_fault = 8'h5A;
   logic [15:0] resp;
   logic [2:0] a;
   int n, n_fail = 0, tests_run = 0;
   int hz[15] = '{0, 50, 100, 150, 200, 250, 300, 350, 400, 450, 500, 133, 166, 233, 266};
   scd_row_t rows[8] = '{'{1, 100, 105, 0}, '{1, 100, 95, 1}, '{0, 100, 104, 1},
      '{0, 100, 106, 0}, '{0, 100, 96, 0}, '{0, 0, 0, 0}, '{0, 511, 536, 0}, '{0, 511, 486, 1}};
   logic [8:0] lt[5] = '{487, 24, 200, 200, 200};
   logic [2:0] la[5] = '{1, 1, 0, 1, 1};
   logic [3:0] lf[5] = '{14, 14, 14, 0, 14};
   logic ld[5] = '{0, 0, 0, 0, 1};
   always #5 clk = ~clk;
   scd_spi_host HOST (.clk, .cs_n(spi_cs_n), .sclk(spi_sclk), .mosi(spi_mosi), .miso(spi_miso));
   scd_ctrl #(.CLK_HZ(CLK_HZ)) DUT (.clk, .reset, .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso,
      .spi_miso_oe, .sense_code, .overvoltage_fault, .thermal_limit_fault, .cal_fault,
      .trim_set, .supply_cal_source, .open_fault_one, .short_fault_one, .open_fault_two,
      .short_fault_two, .out_fault, .drv_on, .diag_pull_direction, .switch_mode, .eff_target);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic xw(input logic [15:0] w);
      HOST.xfer(w, 16, resp);
   endtask
   function automatic logic [15:0] tw(input logic g, input logic ds, input logic [8:0] t);
      return {`SCD_ADDR_TARGET, g, ds, t};
   endfunction
   function automatic logic [15:0] dw(input logic [2:0] c, input logic [2:0] m, input logic [3:0] f);
      return {`SCD_ADDR_DITHER, c, 1'b0, m, f};
   endfunction
   function automatic logic [15:0] idle();
      return {11'h000, drv_on, spi_miso_oe, switch_mode, diag_pull_direction, |eff_target};
   endfunction
   function automatic logic [15:0] st();
      return {14'h0000, switch_mode, drv_on};
   endfunction
   // Skips a half already running, waits for a fresh level, then counts it
   task automatic hold_len(input logic [9:0] v);
      n = 0;
      for (int k = 0; k < 600 && eff_target === v; k++)
         tick(1);
      for (int k = 0; k < 600 && eff_target !== v; k++)
         tick(1);
      while (n < 600 && eff_target === v)
      begin
         tick(1);
         n++;
      end
   endtask
   task automatic results();
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #500000;
      n_fail++;
      results();
   end
   initial
   begin
      tick(12);
      chk(idle(), 16'h0000);
      reset = 1'b0;
      tick(4);
      xw(tw(1'b0, 1'b1, 9'h000));
      chk(resp, 16'hF95A);
      overvoltage_fault = 1'b0;
      short_fault_one = 1'b0;
      open_fault_two = 1'b0;
      out_fault = 8'h00;
      xw(tw(1'b0, 1'b1, 9'h000));
      chk(resp, 16'hB95A);
      xw(tw(1'b0, 1'b1, 9'h000));
      chk(resp, 16'h3000);
      foreach (rows[j])
      begin
         xw(tw(rows[j].g, 1'b1, rows[j].t));
         sense_code = rows[j].s;
         tick(3);
         chk({4'h0, drv_on, diag_pull_direction, eff_target},
            {4'h0, rows[j].d, rows[j].g, 1'b0, rows[j].t});
      end
      xw(tw(1'b0, 1'b0, 9'd200));
      for (int i = 1; i < 15; i++)
      begin
         a = 3'(1 + i % 7);
         xw(dw(3'b000, a, 4'(i)));
         hold_len(10'(200 + a * `SCD_AMP_STEP_LSB));
         chk(16'(n), 16'(CLK_HZ / (2 * hz[i])));
         chk({6'h00, eff_target}, 16'(200 - a * `SCD_AMP_STEP_LSB));
      end
      xw(dw(3'b000, 3'd1, `SCD_FREQ_KEEP));
      hold_len(10'(200 + `SCD_AMP_STEP_LSB));
      chk(16'(n), 16'(CLK_HZ / (2 * hz[14])));
      foreach (lt[j])
      begin
         xw(tw(1'b0, ld[j], lt[j]));
         xw(dw(3'b000, la[j], lf[j]));
         hold_len({1'b0, lt[j]});
         chk(16'(n), 16'd600);
      end
      HOST.xfer(tw(1'b1, 1'b1, 9'd77), 15, resp);
      xw({5'h15, 11'h4FF});
      chk({5'h00, diag_pull_direction, eff_target}, 16'd200);
      sense_code = 10'h3FF;
      xw(dw(3'b011, 3'd0, 4'h0));
      chk(st(), 16'h0003);
      xw(dw(3'b001, 3'd0, 4'h0));
      chk(st(), 16'h0002);
      xw(dw(3'b011, 3'd0, 4'h0));
      thermal_limit_fault = 1'b1;
      tick(3);
      chk(st(), 16'h0002);
      thermal_limit_fault = 1'b0;
      tick(3);
      chk(st(), 16'h0002);
      xw(dw(3'b111, 3'd0, 4'h0));
      chk(st(), 16'h0003);
      reset = 1'b1;
      tick(3);
      chk(idle(), 16'h0000);
      results();
   end
endmodule // scd_ctrl_tb
bind scd_ctrl scd_ctrl_properties PROPS (.clk, .reset, .spi_cs_n, .spi_miso_oe, .sense_code,
   .overvoltage_fault, .thermal_limit_fault, .short_fault_one, .drv_on, .diag_pull_direction,
   .switch_mode, .eff_target);
